/* File: src/adc_ctrl_pkg.sv */
// Package for the A/D converter control block: register map, fields, timing.
// Assumes a single 40 MHz system clock and an AXI4-Lite register bus.
package adc_ctrl_pkg;
  localparam logic [3:0] OFF_START_STATUS = 4'h0;
  localparam logic [3:0] OFF_SRC_REF_CLK = 4'h4;
  localparam logic [3:0] OFF_RESULT_LOW = 4'h8;
  localparam logic [3:0] OFF_RESULT_HIGH = 4'hC;
  localparam logic [3:0] OFF_PIN_FUNC = 4'h0;
  localparam int BIT_START = 7;
  localparam int BIT_BUSY = 6;
  localparam int BIT_POWER = 5;
  localparam int BIT_FORMAT = 4;
  localparam logic [7:0] CTRL_WR_MASK = 8'hB3;
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [7:0] SRC_RESET = 8'h00;
  localparam logic [3:0] PIN_RESET = 4'h0;
  localparam logic [2:0] SRC_BANDGAP = 3'h1;
  localparam logic [2:0] SRC_GND_LO = 3'h2;
  localparam logic [2:0] SRC_GND_HI = 3'h4;
  localparam logic [1:0] REF_SUPPLY = 2'h1;
  localparam logic [4:0] CONV_CLOCKS = 5'h10;
  localparam logic [1:0] AXI_OKAY = 2'h0;
  localparam logic [1:0] AXI_SLVERR = 2'h2;

  typedef enum logic [2:0] {
    SRC_EXT = 3'b001,
    SRC_BG = 3'b010,
    SRC_GND = 3'b100
  } src_route_t;

  typedef struct packed {
    logic [2:0] input_source_select;
    logic [1:0] reference_select;
    logic [2:0] conv_clock_divider_select;
  } src_ref_clk_t;

  typedef struct packed {
    src_route_t route;
    logic [1:0] ext_channel_select;
    logic ref_from_supply;
    logic power_on;
  } analog_ctrl_t;
endpackage : adc_ctrl_pkg

/* File: src/adc_control_input_select.sv */
// A/D converter control: start/busy sequencing, clock divider, source mux,
// result justification and analog pin ownership, behind an AXI4-Lite slave.
// Assumes the analog core returns a 12-bit result valid at conversion end.
//
// Added by the designer: the AXI4-Lite register port and the placing of the registers.
`timescale 1ns/1ps
module adc_control_input_select
  import adc_ctrl_pkg::*;
#(
  parameter int NUM_CH = 4
) (
  input wire logic ref_clk_in,
  input wire logic rst_in,
  input wire logic [3:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [3:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [NUM_CH-1:0] pin_function_select_in,
  input wire logic [NUM_CH-1:0] port_output_enable_in,
  input wire logic [NUM_CH-1:0] pullup_enable_in,
  input wire logic [11:0] core_result_in,
  output analog_ctrl_t analog_ctrl_out,
  output logic [NUM_CH-1:0] pin_analog_select_out,
  output logic [NUM_CH-1:0] pin_output_enable_out,
  output logic [NUM_CH-1:0] pin_pullup_enable_out,
  output logic conv_clock_en_out,
  output logic sample_out,
  output logic conv_done_irq_out
);
  logic [7:0] ctrl_r;
  src_ref_clk_t src_r;
  logic busy_r;
  logic [4:0] tick_cnt_r;
  logic [6:0] div_cnt_r;
  logic [7:0] res_low_r;
  logic [7:0] res_high_r;
  logic done_r;
  logic aw_held_r;
  logic w_held_r;
  logic [3:0] awaddr_r;
  logic [7:0] wdata_r;
  logic wstrb0_r;
  logic div_tick;
  logic launch;
  logic finish;
  logic do_write;
  logic [6:0] div_max;
  logic [15:0] justified;

  // Bus write: address and data are caught independently, either order
  assign s_axi_awready = !aw_held_r && !s_axi_bvalid;
  assign s_axi_wready = !w_held_r && !s_axi_bvalid;
  assign do_write = aw_held_r && w_held_r && !s_axi_bvalid;

  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      aw_held_r <= 1'b0;
      w_held_r <= 1'b0;
      awaddr_r <= 4'h0;
      wdata_r <= 8'h00;
      wstrb0_r <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= AXI_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held_r <= 1'b1;
        awaddr_r <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held_r <= 1'b1;
        wdata_r <= s_axi_wdata[7:0];
        wstrb0_r <= s_axi_wstrb[0];
      end
      if (do_write) begin
        aw_held_r <= 1'b0;
        w_held_r <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= (awaddr_r == OFF_START_STATUS || awaddr_r == OFF_SRC_REF_CLK ||
                        awaddr_r == OFF_RESULT_LOW || awaddr_r == OFF_RESULT_HIGH) ?
                       AXI_OKAY : AXI_SLVERR;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // Control registers; busy is hardware-owned and never written
  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      ctrl_r <= CTRL_RESET;
      src_r <= SRC_RESET;
    end else if (do_write && wstrb0_r) begin
      if (awaddr_r == OFF_START_STATUS) begin
        ctrl_r <= wdata_r & CTRL_WR_MASK;
      end
      if (awaddr_r == OFF_SRC_REF_CLK) begin
        src_r <= wdata_r;
      end
    end
  end

  // Launch on the falling write of start after it was high; power must be on
  assign launch = ctrl_r[BIT_START] && do_write && wstrb0_r &&
                  awaddr_r == OFF_START_STATUS && !wdata_r[BIT_START] &&
                  wdata_r[BIT_POWER] && !busy_r;

  // Divider: count reloads at the selected ratio minus one
  assign div_max = 7'((8'h01 << src_r.conv_clock_divider_select) - 8'h01);
  assign div_tick = (div_cnt_r >= div_max);

  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      div_cnt_r <= 7'h00;
    end else if (div_tick || launch) begin
      div_cnt_r <= 7'h00;
    end else begin
      div_cnt_r <= div_cnt_r + 7'h01;
    end
  end

  // Power loss abandons the conversion: no result update and no request
  assign finish = busy_r && ctrl_r[BIT_POWER] && div_tick &&
                  tick_cnt_r == CONV_CLOCKS - 5'h01;

  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      busy_r <= 1'b0;
      tick_cnt_r <= 5'h00;
    end else if (launch) begin
      busy_r <= 1'b1;
      tick_cnt_r <= 5'h00;
    end else if (!ctrl_r[BIT_POWER]) begin
      busy_r <= 1'b0;
    end else if (finish) begin
      busy_r <= 1'b0;
    end else if (busy_r && div_tick) begin
      tick_cnt_r <= tick_cnt_r + 5'h01;
    end
  end

  assign justified = ctrl_r[BIT_FORMAT] ? {4'h0, core_result_in} :
                     {core_result_in, 4'h0};

  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      res_low_r <= 8'h00;
      res_high_r <= 8'h00;
      done_r <= 1'b0;
    end else begin
      done_r <= finish;
      if (finish) begin
        res_low_r <= justified[7:0];
        res_high_r <= justified[15:8];
      end
    end
  end

  // Read channel
  assign s_axi_arready = !s_axi_rvalid;
  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= AXI_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= AXI_OKAY;
      case (s_axi_araddr)
        OFF_START_STATUS: s_axi_rdata <= {24'h0, ctrl_r[BIT_START], busy_r, ctrl_r[BIT_POWER:0]};
        OFF_SRC_REF_CLK: s_axi_rdata <= {24'h0, src_r};
        OFF_RESULT_LOW: s_axi_rdata <= {24'h0, res_low_r};
        OFF_RESULT_HIGH: s_axi_rdata <= {24'h0, res_high_r};
        default: begin
          s_axi_rdata <= 32'h0000_0000;
          s_axi_rresp <= AXI_SLVERR;
        end
      endcase
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // Source routing: one-hot, so only one source reaches the converter
  always_comb begin
    analog_ctrl_out.route = SRC_EXT;
    if (src_r.input_source_select == SRC_BANDGAP) begin
      analog_ctrl_out.route = SRC_BG;
    end else if (src_r.input_source_select >= SRC_GND_LO &&
                 src_r.input_source_select <= SRC_GND_HI) begin
      analog_ctrl_out.route = SRC_GND;
    end
    analog_ctrl_out.ext_channel_select = ctrl_r[1:0];
    analog_ctrl_out.ref_from_supply = (src_r.reference_select == REF_SUPPLY);
    analog_ctrl_out.power_on = ctrl_r[BIT_POWER];
  end

  assign conv_clock_en_out = busy_r && div_tick;
  assign sample_out = busy_r;
  assign conv_done_irq_out = done_r;

  genvar g;
  generate
    for (g = 0; g < NUM_CH; g++) begin : g_pin
      assign pin_analog_select_out[g] = pin_function_select_in[g];
      assign pin_output_enable_out[g] = port_output_enable_in[g] &&
                                        !pin_function_select_in[g];
      assign pin_pullup_enable_out[g] = pullup_enable_in[g] &&
                                        !pin_function_select_in[g];
    end
  endgenerate

  property p_busy_len;
    @(posedge ref_clk_in) disable iff (rst_in)
      (launch && src_r.conv_clock_divider_select == 3'h0 && ctrl_r[BIT_POWER])
      |=> busy_r [*8];
  endproperty
  a_busy_len: assert property (p_busy_len) else $error("busy dropped early");

  property p_irq_follows;
    @(posedge ref_clk_in) disable iff (rst_in)
      finish |=> conv_done_irq_out && !busy_r;
  endproperty
  a_irq_follows: assert property (p_irq_follows) else $error("no irq at end");

  property p_pullup_off;
    @(posedge ref_clk_in) disable iff (rst_in)
      |pin_function_select_in |-> ((pin_pullup_enable_out & pin_function_select_in) == '0);
  endproperty
  a_pullup_off: assert property (p_pullup_off) else $error("pullup on analog pin");

  // Named steps of a conversion, shared by the properties below
  sequence s_busy_run;
    busy_r && sample_out && !conv_done_irq_out;
  endsequence

  sequence s_power_down;
    !analog_ctrl_out.power_on && !launch;
  endsequence

  sequence s_irq_pulse;
    conv_done_irq_out ##1 !conv_done_irq_out;
  endsequence

  property p_busy_rise;
    @(posedge ref_clk_in) disable iff (rst_in)
      launch |=> s_busy_run;
  endproperty
  a_busy_rise: assert property (p_busy_rise) else $error("busy not raised");

  // Dropping power mid-conversion must not leave software polling forever
  property p_power_abort;
    @(posedge ref_clk_in) disable iff (rst_in)
      s_power_down |=> !busy_r;
  endproperty
  a_power_abort: assert property (p_power_abort) else $error("busy unpowered");

  property p_irq_single;
    @(posedge ref_clk_in) disable iff (rst_in)
      finish |=> s_irq_pulse;
  endproperty
  a_irq_single: assert property (p_irq_single) else $error("irq not single");

  property p_result_capture;
    @(posedge ref_clk_in) disable iff (rst_in)
      finish |=> ({res_high_r, res_low_r} == $past(justified));
  endproperty
  a_result_capture: assert property (p_result_capture) else $error("bad result");

  // Results must only move at completion, never mid-conversion
  property p_result_hold;
    @(posedge ref_clk_in) disable iff (rst_in)
      !finish |=> ($stable(res_high_r) && $stable(res_low_r));
  endproperty
  a_result_hold: assert property (p_result_hold) else $error("result changed");

  property p_route_onehot;
    @(posedge ref_clk_in) disable iff (rst_in)
      $onehot(analog_ctrl_out.route);
  endproperty
  a_route_onehot: assert property (p_route_onehot) else $error("route not one-hot");

  property p_oe_off;
    @(posedge ref_clk_in) disable iff (rst_in)
      ((pin_output_enable_out & pin_function_select_in) == '0);
  endproperty
  a_oe_off: assert property (p_oe_off) else $error("drive on analog pin");
endmodule : adc_control_input_select

/* File: tb/adc_control_input_select_tb.sv */
// Self-checking bench for the A/D control block, driven over AXI4-Lite.
// Assumes the analog core is replaced by a 12-bit result, all ones first and then random, held stable.
`timescale 1ns/1ps
module adc_control_input_select_tb;
  import adc_ctrl_pkg::*;
  logic ref_clk_in = 1'b0;
  logic rst_in = 1'b1;
  logic [3:0] awaddr = 4'h0, araddr = 4'h0, wstrb = 4'hF;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [31:0] wdata = 32'h0;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  logic [3:0] sel = 4'h0, oe = 4'h0, pu = 4'h0, an_sel, an_oe, an_pu;
  logic [11:0] res = 12'h0;
  analog_ctrl_t actl;
  logic clk_en, sample, irq, clr = 1'b1;
  int bad_count = 0, cmp_count = 0, bc, ic, kc, i, d, f, c;
  logic [31:0] rv;
  logic [1:0] rs;

  always #12.5 ref_clk_in = ~ref_clk_in;

  adc_control_input_select u_dut (.ref_clk_in(ref_clk_in), .rst_in(rst_in),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .pin_function_select_in(sel), .port_output_enable_in(oe), .pullup_enable_in(pu),
    .core_result_in(res), .analog_ctrl_out(actl), .pin_analog_select_out(an_sel),
    .pin_output_enable_out(an_oe), .pin_pullup_enable_out(an_pu),
    .conv_clock_en_out(clk_en), .sample_out(sample), .conv_done_irq_out(irq));

  // Busy cycles and completion pulses, counted since the last clear
  always @(posedge ref_clk_in) begin
    if (clr) begin
      bc <= 0;
      ic <= 0;
      kc <= 0;
    end else begin
      bc <= bc + int'(sample);
      ic <= ic + int'(irq);
      kc <= kc + int'(clk_en);
    end
  end

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    cmp_count++;
    if (g !== e) begin
      bad_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : chk

  task automatic wr(input logic [3:0] a, input logic [31:0] v);
    logic done;
    done = 1'b0;
    @(posedge ref_clk_in);
    awaddr <= a;
    awvalid <= 1'b1;
    wdata <= v;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!done) begin
      @(posedge ref_clk_in);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid === 1'b1) begin
        done = 1'b1;
        rs = bresp;
        bready <= 1'b0;
      end
    end
  endtask : wr

  task automatic rd(input logic [3:0] a);
    logic done;
    done = 1'b0;
    @(posedge ref_clk_in);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    while (!done) begin
      @(posedge ref_clk_in);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid === 1'b1) begin
        done = 1'b1;
        rv = rdata;
        rs = rresp;
        rready <= 1'b0;
      end
    end
  endtask : rd

  function automatic logic [2:0] route_exp(input int s);
    if (s == 1) return SRC_BG;
    if (s >= 2 && s <= 4) return SRC_GND;
    return SRC_EXT;
  endfunction : route_exp

  function automatic logic [31:0] hi_exp(input logic [11:0] r, input int fm);
    return fm ? {28'h0, r[11:8]} : {24'h0, r[11:4]};
  endfunction : hi_exp

  function automatic logic [31:0] lo_exp(input logic [11:0] r, input int fm);
    return fm ? {24'h0, r[7:0]} : {24'h0, r[3:0], 4'h0};
  endfunction : lo_exp

  task automatic final_report;
    $display("Comparisons %0d, mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : final_report

  // Whole run needs well under 20000 cycles
  initial begin
    #(25 * 20000);
    bad_count++;
    final_report();
  end

  initial begin
    i = $urandom(4);
    repeat (16) @(posedge ref_clk_in);
    rst_in <= 1'b0;
    rd(OFF_START_STATUS); chk(rv, 32'h0);
    rd(OFF_SRC_REF_CLK); chk(rv, 32'h0);
    rd(4'h2); chk({30'h0, rs}, {30'h0, AXI_SLVERR});
    wr(4'h2, 32'hFF); chk({30'h0, rs}, {30'h0, AXI_SLVERR});
    $display("test reset and map done");
    for (i = 0; i < 8; i++) begin
      c = $urandom % 4;
      wr(OFF_START_STATUS, 32'h20 | c);
      wr(OFF_SRC_REF_CLK, (i << 5) | ((i % 4) << 3));
      chk(actl.route, route_exp(i));
      chk(actl.ext_channel_select, c);
      chk(actl.ref_from_supply, (i % 4) == 1);
      chk(actl.power_on, 1'b1);
    end
    $display("test source routing done");
    for (i = 0; i < 8; i++) begin
      @(posedge ref_clk_in);
      sel <= 4'($urandom);
      oe <= 4'($urandom);
      pu <= 4'($urandom);
      @(posedge ref_clk_in);
      chk(an_sel, sel);
      chk(an_oe, oe & ~sel);
      chk(an_pu, pu & ~sel);
    end
    sel <= 4'h0;
    $display("test pin ownership done");
    for (i = 0; i < 4; i++) begin
      d = (i == 3) ? 7 : i;
      f = i % 2;
      res <= (i == 0) ? 12'hFFF : 12'($urandom);
      wr(OFF_SRC_REF_CLK, d); chk({30'h0, rs}, {30'h0, AXI_OKAY});
      clr <= 1'b1;
      wr(OFF_START_STATUS, 32'hA0 | (f << 4));
      clr <= 1'b0;
      wr(OFF_START_STATUS, 32'h20 | (f << 4));
      rd(OFF_START_STATUS); chk(rv[6], 1'b1);
      c = 0;
      while (sample !== 1'b0 && c < 5000) begin
        @(posedge ref_clk_in);
        c++;
      end
      repeat (3) @(posedge ref_clk_in);
      chk(bc, 16 << d);
      chk(ic, 1);
      chk(kc, 16);
      rd(OFF_START_STATUS); chk(rv, 32'h20 | (f << 4));
      rd(OFF_RESULT_HIGH); chk(rv, hi_exp(res, f));
      rd(OFF_RESULT_LOW); chk(rv, lo_exp(res, f));
    end
    $display("test conversions done");
    // Refused starts, read-only busy, ignored strobe, then a power-off abort
    clr <= 1'b1;
    wr(OFF_START_STATUS, 32'hE0);
    clr <= 1'b0;
    rd(OFF_START_STATUS); chk(rv, 32'hA0);
    wr(OFF_START_STATUS, 32'h00);
    rd(OFF_START_STATUS); chk(rv, 32'h0);
    chk(bc, 0);
    wstrb <= 4'h0;
    wr(OFF_SRC_REF_CLK, 32'hFF);
    wstrb <= 4'hF;
    rd(OFF_SRC_REF_CLK); chk(rv, 32'h7);
    wr(OFF_START_STATUS, 32'hA0);
    wr(OFF_START_STATUS, 32'h20);
    rd(OFF_START_STATUS); chk(rv[6], 1'b1);
    wr(OFF_START_STATUS, 32'h00);
    rd(OFF_START_STATUS); chk(rv, 32'h0);
    chk(ic, 0);
    $display("test refused and abort done");
    final_report();
  end
endmodule : adc_control_input_select_tb
